//--- verilog/ee_slave.sv
// two-wire slave front end, write controller and protection flags of the memory
`timescale 1ns/1ps

module ee_slave
    import ee_pkg::*;
#(
    parameter logic [TIMER_W-1:0] WR_CYCLES_P = TIMER_W'(WRITE_CYCLES)
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic select_input_0_in,
    input wire logic select_input_1_in,
    input wire logic select_input_2_in,
    input wire logic wp_in,
    input wire logic high_voltage_level_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out
);

    ee_state_s state_reg; // registered state
    ee_state_s state_next; // next state
    logic [PIN_W-1:0] pins_raw; // raw pin levels
    logic scl_rise; // filtered clock rising
    logic scl_fall; // filtered clock falling
    logic start_ev; // start seen this cycle
    logic stop_ev; // stop seen this cycle
    logic wp_lvl; // filtered protect pin

    // a byte is protected by the pin everywhere, by either flag in the low half
    function automatic logic is_protected(input logic [7:0] addr, input logic wp,
                                          input logic pflag, input logic rflag);
        is_protected = wp | ((pflag | rflag) & ~addr[7]);
    endfunction

    // all pins pass the same three-stage filter; floating pins are pulled low outside
    assign pins_raw = {high_voltage_level_in, wp_in, select_input_2_in,
                       select_input_1_in, select_input_0_in, sda_in, scl_in};

    // events use the filtered levels so a glitch on one stage never counts
    always_comb begin
        logic [PIN_W-1:0] f_new;
        f_new = ((state_reg.s2 ~^ state_reg.s3) & state_reg.s3)
              | ((state_reg.s2 ^ state_reg.s3) & state_reg.filt);
        scl_rise = ~state_reg.filt[PIN_SCL] & f_new[PIN_SCL];
        scl_fall = state_reg.filt[PIN_SCL] & ~f_new[PIN_SCL];
        // data edges with the clock steady high are framing, not data
        start_ev = state_reg.filt[PIN_SCL] & f_new[PIN_SCL]
                 & state_reg.filt[PIN_SDA] & ~f_new[PIN_SDA];
        stop_ev = state_reg.filt[PIN_SCL] & f_new[PIN_SCL]
                & ~state_reg.filt[PIN_SDA] & f_new[PIN_SDA];
        wp_lvl = state_reg.filt[PIN_WP];
    end

    // next-state logic for the whole slave
    always_comb begin
        logic [7:0] b;
        logic [2:0] pins_sel;
        logic sel_ok;
        logic rev_ok;
        logic ok;
        ee_op_e op_new;
        b = state_reg.shift;
        pins_sel = {state_reg.filt[PIN_SEL2], state_reg.filt[PIN_SEL1],
                    state_reg.filt[PIN_SEL0]};
        sel_ok = (b[3:1] == pins_sel);
        // reversible commands need the lowest select at the high voltage level
        rev_ok = state_reg.filt[PIN_HV]
               & (b[3:1] == {pins_sel[2], pins_sel[1], 1'b1});
        ok = 1'b0;
        op_new = EE_OP_NONE;
        state_next = state_reg;

        // synchroniser chain: first stage feeds only the second
        state_next.s1 = pins_raw;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.filt = ((state_reg.s2 ~^ state_reg.s3) & state_reg.s3)
                        | ((state_reg.s2 ^ state_reg.s3) & state_reg.filt);
        state_next.sda_lvl = 1'b0;
        state_next.rdata = 8'h00;

        // register port: array peek, status and control
        if (reg_rd_in) begin
            if (!reg_addr_in[REG_SPACE_BIT]) begin
                state_next.rdata = state_reg.mem[reg_addr_in[7:0]];
            end else if (reg_addr_in == REG_STATUS) begin
                state_next.rdata[STAT_BUSY] = (state_reg.phase == EE_BUSY);
                state_next.rdata[STAT_PERM] = state_reg.permanent_protect_flag;
                state_next.rdata[STAT_REV] = state_reg.reversible_protect_flag;
                state_next.rdata[STAT_IDLE] = (state_reg.phase == EE_IDLE);
            end else if (reg_addr_in == REG_CTRL) begin
                state_next.rdata[CTRL_BUS_EN] = state_reg.bus_en;
            end
        end
        if (reg_wr_in && reg_addr_in == REG_CTRL) begin
            state_next.bus_en = reg_wdata_in[CTRL_BUS_EN];
        end

        case (state_reg.phase)
            // self-timed write: every bus event is ignored, so polls get no ack
            EE_BUSY: begin
                state_next.sda_oe = 1'b0;
                if (state_reg.timer == '0) begin
                    state_next.phase = EE_IDLE;
                end else begin
                    state_next.timer = state_reg.timer - 1'b1;
                end
            end
            default: begin
                if (!state_reg.bus_en) begin
                    // slave switched off: drop off the bus at once
                    state_next.phase = EE_IDLE;
                    state_next.sda_oe = 1'b0;
                    state_next.ack = 1'b0;
                end else if (start_ev) begin
                    // a start aborts anything, which also gives bus recovery
                    state_next.phase = EE_DEV;
                    state_next.cnt = '0;
                    state_next.ack = 1'b0;
                    state_next.sda_oe = 1'b0;
                    state_next.got_data = 1'b0;
                    state_next.valid = '0;
                    state_next.op = EE_OP_NONE;
                end else if (stop_ev) begin
                    state_next.sda_oe = 1'b0;
                    state_next.ack = 1'b0;
                    state_next.phase = EE_IDLE;
                    if (state_reg.phase == EE_DATA && state_reg.got_data) begin
                        // commit now, then hold busy for the full time either way
                        state_next.phase = EE_BUSY;
                        state_next.timer = WR_CYCLES_P - 1'b1;
                        case (state_reg.op)
                            EE_OP_ARRAY: begin
                                for (int i = 0; i < PAGE_BYTES; i++) begin
                                    if (state_reg.valid[i] && !is_protected(
                                            {state_reg.waddr[7:4], 4'(i)}, wp_lvl,
                                            state_reg.permanent_protect_flag,
                                            state_reg.reversible_protect_flag)) begin
                                        state_next.mem[{state_reg.waddr[7:4], 4'(i)}] =
                                            state_reg.page[i];
                                    end
                                end
                            end
                            EE_OP_SET_PERM: begin
                                if (!wp_lvl) begin
                                    state_next.permanent_protect_flag = 1'b1;
                                end
                            end
                            EE_OP_SET_REV: begin
                                if (!wp_lvl) begin
                                    state_next.reversible_protect_flag = 1'b1;
                                end
                            end
                            EE_OP_CLR_REV: begin
                                if (!wp_lvl) begin
                                    state_next.reversible_protect_flag = 1'b0;
                                end
                            end
                            default: begin
                                state_next.phase = EE_IDLE;
                            end
                        endcase
                    end
                end else if (state_reg.phase != EE_IDLE) begin
                    if (scl_rise && state_reg.cnt < BIT_LAST) begin
                        // sample data on the rising clock, msb first
                        state_next.shift = {state_reg.shift[6:0],
                                            state_reg.filt[PIN_SDA]};
                        state_next.cnt = state_reg.cnt + 1'b1;
                    end else if (scl_fall && state_reg.ack) begin
                        // end of the ninth clock: let the line go
                        state_next.ack = 1'b0;
                        state_next.sda_oe = 1'b0;
                        state_next.cnt = '0;
                        if (state_reg.phase == EE_DEV) begin
                            state_next.phase = (state_reg.op == EE_OP_READ) ?
                                               EE_READ : EE_WADDR;
                        end else if (state_reg.phase == EE_WADDR) begin
                            state_next.phase = EE_DATA;
                        end
                    end else if (scl_fall && state_reg.cnt == BIT_LAST) begin
                        // a byte is in: decide and start the acknowledge bit
                        case (state_reg.phase)
                            EE_DEV: begin
                                if (b[7:4] == PRE_ARRAY && sel_ok) begin
                                    ok = 1'b1;
                                    op_new = b[0] ? EE_OP_READ : EE_OP_ARRAY;
                                end else if (b[7:4] == PRE_PROT
                                             && !state_reg.permanent_protect_flag) begin
                                    if (rev_ok) begin
                                        if (b[0]) begin
                                            ok = !state_reg.reversible_protect_flag;
                                            op_new = EE_OP_READ;
                                        end else if (b[3:1] == SEL_SET_REV) begin
                                            ok = !state_reg.reversible_protect_flag;
                                            op_new = EE_OP_SET_REV;
                                        end else if (b[3:1] == SEL_CLR_REV) begin
                                            ok = 1'b1;
                                            op_new = EE_OP_CLR_REV;
                                        end
                                    end else if (sel_ok) begin
                                        ok = 1'b1;
                                        op_new = b[0] ? EE_OP_READ : EE_OP_SET_PERM;
                                    end
                                end
                                if (ok) begin
                                    state_next.ack = 1'b1;
                                    state_next.sda_oe = 1'b1;
                                    state_next.op = op_new;
                                end else begin
                                    // no match: release and fall back to standby
                                    state_next.phase = EE_IDLE;
                                end
                            end
                            EE_WADDR: begin
                                state_next.waddr = b;
                                state_next.ack = 1'b1;
                                state_next.sda_oe = 1'b1;
                            end
                            EE_DATA: begin
                                // buffer the byte; later bytes overwrite on wrap
                                state_next.page[state_reg.waddr[3:0]] = b;
                                state_next.valid[state_reg.waddr[3:0]] = 1'b1;
                                state_next.waddr = {state_reg.waddr[7:4],
                                                    state_reg.waddr[3:0] + 4'h1};
                                state_next.got_data = 1'b1;
                                state_next.ack = 1'b1;
                                state_next.sda_oe = 1'b1;
                            end
                            default: begin
                                // read phase: the ninth clock is the host's, restart
                                state_next.cnt = '0;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // one register for the whole state; flags start clear, array starts erased
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg.s1 <= PINS_RESET;
            state_reg.s2 <= PINS_RESET;
            state_reg.s3 <= PINS_RESET;
            state_reg.filt <= PINS_RESET;
            state_reg.phase <= EE_IDLE;
            state_reg.op <= EE_OP_NONE;
            state_reg.cnt <= '0;
            state_reg.ack <= 1'b0;
            state_reg.shift <= '0;
            state_reg.waddr <= '0;
            state_reg.got_data <= 1'b0;
            state_reg.valid <= '0;
            state_reg.page <= '0;
            state_reg.mem <= {MEM_BYTES{MEM_ERASED}};
            state_reg.permanent_protect_flag <= 1'b0;
            state_reg.reversible_protect_flag <= 1'b0;
            state_reg.timer <= '0;
            state_reg.bus_en <= 1'b1;
            state_reg.sda_oe <= 1'b0;
            state_reg.sda_lvl <= 1'b0;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign sda_out = state_reg.sda_lvl;
    assign sda_oe_out = state_reg.sda_oe;
    assign reg_rdata_out = state_reg.rdata;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    // acknowledge drive: pulled low from the eighth falling edge to the ninth
    sequence ack_begin_s;
        scl_fall && state_reg.cnt == BIT_LAST && !state_reg.ack
            && state_reg.phase inside {EE_WADDR, EE_DATA} && !start_ev && !stop_ev;
    endsequence
    sequence ack_hold_s;
        sda_oe_out && state_reg.ack;
    endsequence

    byte_ack_a: assert property (ack_begin_s |=> ack_hold_s)
        else $error("received byte not acknowledged");
    start_frame_a: assert property (start_ev && state_reg.phase != EE_BUSY
                                    && state_reg.bus_en
                                    |=> state_reg.phase == EE_DEV && state_reg.cnt == 0)
        else $error("start did not open a device address frame");
    drive_ack_only_a: assert property (sda_oe_out |-> state_reg.ack && !sda_out)
        else $error("data line driven outside an acknowledge");
    busy_hold_a: assert property (state_reg.phase == EE_BUSY && state_reg.timer != 0
                                  |=> state_reg.phase == EE_BUSY)
        else $error("write cycle ended early");
    busy_quiet_a: assert property (state_reg.phase == EE_BUSY |=> !sda_oe_out)
        else $error("acknowledge during write cycle");
    page_wrap_a: assert property ((ack_begin_s and (state_reg.phase == EE_DATA))
                                  |=> state_reg.waddr[7:4] == $past(state_reg.waddr[7:4])
                                  && state_reg.waddr[3:0] == $past(state_reg.waddr[3:0]) + 4'h1)
        else $error("page address did not wrap inside its page");
    wp_array_a: assert property (wp_lvl && state_reg.phase != EE_BUSY
                                 ##1 state_reg.phase == EE_BUSY
                                 |-> state_reg.mem == $past(state_reg.mem))
        else $error("array changed while pin protected");
    wp_flags_a: assert property (wp_lvl && stop_ev |=> $stable(state_reg.permanent_protect_flag)
                                 && $stable(state_reg.reversible_protect_flag))
        else $error("protection flag changed while pin high");
    perm_sticky_a: assert property (state_reg.permanent_protect_flag
                                    |=> state_reg.permanent_protect_flag)
        else $error("permanent flag cleared");
    perm_nack_a: assert property (scl_fall && state_reg.cnt == BIT_LAST
                                  && state_reg.phase == EE_DEV && !state_reg.ack
                                  && state_reg.shift[7:4] == PRE_PROT
                                  && state_reg.permanent_protect_flag && !start_ev && !stop_ev
                                  |=> !sda_oe_out ##1 !sda_oe_out)
        else $error("protect command acknowledged after permanent lock");
    // a word with neither preamble is refused: line released, back to standby
    dev_nack_a: assert property (scl_fall && state_reg.cnt == BIT_LAST
                                 && state_reg.phase == EE_DEV && !state_reg.ack
                                 && state_reg.shift[7:4] != PRE_ARRAY
                                 && state_reg.shift[7:4] != PRE_PROT
                                 && !start_ev && !stop_ev
                                 |=> !sda_oe_out && state_reg.phase == EE_IDLE)
        else $error("unknown device word acknowledged");
    // the write cycle hands back to standby once its timer has run out
    busy_end_a: assert property (state_reg.phase == EE_BUSY && state_reg.timer == 0
                                 |=> state_reg.phase == EE_IDLE)
        else $error("write cycle did not return to standby");
    // a set command for an already set reversible flag must go unanswered
    rev_nack_a: assert property (scl_fall && state_reg.cnt == BIT_LAST
                                 && state_reg.phase == EE_DEV && !state_reg.ack
                                 && state_reg.shift == {PRE_PROT, SEL_SET_REV, 1'b0}
                                 && state_reg.filt[PIN_HV] && state_reg.reversible_protect_flag
                                 && !start_ev && !stop_ev |=> !sda_oe_out)
        else $error("redundant reversible set acknowledged");

endmodule

//--- verilog/ee_pkg.sv
// shared constants, enums and state layout of the two-wire protected memory slave
package ee_pkg;
    // timing of the self-timed write cycle
    localparam int REF_CLK_PERIOD_NS = 40;
    localparam int WRITE_CYCLE_TIME_MS = 5;
    // longest time, so the cycle count rounds down
    localparam int WRITE_CYCLES = (WRITE_CYCLE_TIME_MS * 1000000) / REF_CLK_PERIOD_NS;
    localparam int TIMER_W = 20;

    // memory geometry
    localparam int MEM_BYTES = 256;
    localparam int PAGE_BYTES = 16;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // device address preambles and reversible-flag select patterns
    localparam logic [3:0] PRE_ARRAY = 4'ha;
    localparam logic [3:0] PRE_PROT = 4'h6;
    localparam logic [2:0] SEL_SET_REV = 3'h1;
    localparam logic [2:0] SEL_CLR_REV = 3'h3;

    // bit positions in the synchronised pin vector
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SEL0 = 2;
    localparam int PIN_SEL1 = 3;
    localparam int PIN_SEL2 = 4;
    localparam int PIN_WP = 5;
    localparam int PIN_HV = 6;
    localparam int PIN_W = 7;

    // register port map
    localparam logic [8:0] REG_STATUS = 9'h100;
    localparam logic [8:0] REG_CTRL = 9'h101;
    localparam int REG_SPACE_BIT = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PERM = 1;
    localparam int STAT_REV = 2;
    localparam int STAT_IDLE = 3;
    localparam int CTRL_BUS_EN = 0;

    // reset values
    localparam logic [7:0] MEM_ERASED = 8'hff;
    localparam logic [6:0] PINS_RESET = 7'h03;

    // bus phase of the slave
    typedef enum logic [2:0] {
        EE_IDLE,
        EE_DEV,
        EE_WADDR,
        EE_DATA,
        EE_READ,
        EE_BUSY
    } ee_phase_e;

    // command selected by the device address word
    typedef enum logic [2:0] {
        EE_OP_NONE,
        EE_OP_ARRAY,
        EE_OP_READ,
        EE_OP_SET_PERM,
        EE_OP_SET_REV,
        EE_OP_CLR_REV
    } ee_op_e;

    // whole state of the slave
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] filt;
        ee_phase_e phase;
        ee_op_e op;
        logic [3:0] cnt;
        logic ack;
        logic [7:0] shift;
        logic [7:0] waddr;
        logic got_data;
        logic [PAGE_BYTES-1:0] valid;
        logic [PAGE_BYTES-1:0][7:0] page;
        logic [MEM_BYTES-1:0][7:0] mem;
        logic permanent_protect_flag;
        logic reversible_protect_flag;
        logic [TIMER_W-1:0] timer;
        logic bus_en;
        logic sda_oe;
        logic sda_lvl;
        logic [7:0] rdata;
    } ee_state_s;
endpackage

//--- verif/ee_host.sv
// two-wire bus host model that drives the serial pins of the memory slave
`timescale 1ns/1ps
module ee_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // both lines idle high; the link clock stands still between frames
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one link clock: data moves early in the long low phase, level taken late in high
    task automatic bit_x(input logic b, output logic s);
        scl_out <= 1'b0;
        @(posedge clk_in);
        sda_out <= b;
        repeat (5) @(posedge clk_in);
        scl_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        s = sda_in;
    endtask
    // data edge with the clock high: lvl 0 makes a start, lvl 1 a stop
    task automatic cond(input logic lvl);
        scl_out <= 1'b0;
        @(posedge clk_in);
        sda_out <= ~lvl;
        repeat (5) @(posedge clk_in);
        scl_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        sda_out <= lvl;
        repeat (3) @(posedge clk_in);
    endtask
    // eight bits msb first, then a ninth clock with the data line released
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the protected two-wire memory slave
`timescale 1ns/1ps
module tb_top;
    import ee_pkg::*;
    localparam int WR = 200; // short write cycle so polling can catch it busy
    logic clk, rst_n, wp, hv, reg_wr, reg_rd;
    logic [2:0] sel;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, rdata;
    wire logic scl, host_sda, oe, drv;
    wire logic sda = host_sda & ~oe; // open drain with pull-up
    int error_cnt = 0;
    int checked = 0;
    ee_slave #(.WR_CYCLES_P(TIMER_W'(WR))) dut (.ref_clk_in(clk), .reset_n_in(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(drv), .sda_oe_out(oe),
        .select_input_0_in(sel[0]), .select_input_1_in(sel[1]), .select_input_2_in(sel[2]),
        .wp_in(wp), .high_voltage_level_in(hv), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata));
    ee_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(host_sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // register read: data stands only in the cycle after the strobe
    task automatic rc(input logic [8:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk("reg", rdata, exp);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // start, bytes with their expected acks, stop, then a pause of gap clocks
    task automatic cmd(input logic [7:0] b[$], input logic [31:0] acks, input int gap);
        logic a;
        host.cond(1'b0);
        foreach (b[i]) begin
            host.send(b[i], a);
            chk("ack", {7'h0, a}, {7'h0, acks[i]});
            chk("sda_out", {7'h0, drv}, 8'h00);
        end
        host.cond(1'b1);
        repeat (gap) @(posedge clk);
    endtask
    task automatic t_page;
        logic [7:0] q[$];
        q = '{8'haa, 8'h3e};
        for (int i = 0; i < 17; i++) q.push_back(8'h40 + 8'(i));
        cmd(q, 32'h7ffff, 4);
        rc(9'h100, 8'h01);
        cmd('{8'haa}, 0, WR);
        cmd('{8'haa}, 1, 8);
        rc(9'h03e, 8'h50);
        rc(9'h03f, 8'h41);
        rc(9'h030, 8'h42);
        rc(9'h040, 8'hff);
    endtask
    task automatic t_addr;
        cmd('{8'ha8}, 0, 20);
        cmd('{8'hab}, 1, 20);
        wr(9'h101, 8'h00);
        cmd('{8'haa}, 0, 20);
        wr(9'h101, 8'h01);
        rc(9'h101, 8'h01);
    endtask
    task automatic t_prot;
        logic s;
        host.cond(1'b0);
        repeat (9) host.bit_x(1'b1, s);
        host.cond(1'b0);
        host.cond(1'b1);
        sel <= 3'b000;
        hv <= 1'b1;
        cmd('{8'h62, 8'h00, 8'h00}, 7, WR + 8);
        rc(9'h100, 8'h0c);
        cmd('{8'h62}, 0, 20);
        sel <= 3'b101;
        hv <= 1'b0;
        cmd('{8'haa, 8'h10, 8'h11}, 7, WR + 8);
        cmd('{8'haa, 8'h90, 8'h22}, 7, WR + 8);
        rc(9'h010, 8'hff);
        rc(9'h090, 8'h22);
        wp <= 1'b1;
        cmd('{8'haa, 8'h91, 8'h33}, 7, WR + 8);
        rc(9'h091, 8'hff);
        sel <= 3'b010;
        hv <= 1'b1;
        cmd('{8'h66, 8'h00, 8'h00}, 7, WR + 8);
        rc(9'h100, 8'h0c);
        wp <= 1'b0;
        cmd('{8'h66, 8'h00, 8'h00}, 7, WR + 8);
        rc(9'h100, 8'h08);
        sel <= 3'b101;
        hv <= 1'b0;
        cmd('{8'h6b}, 1, 20);
        cmd('{8'h6a, 8'h00, 8'h00}, 7, WR + 8);
        rc(9'h100, 8'h0a);
        cmd('{8'h6a}, 0, 20);
        cmd('{8'h6b}, 0, 20);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog sized well above the roughly six thousand clocks the tests need
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        close_out;
    end
    initial begin
        {rst_n, wp, hv, reg_wr, reg_rd} = 5'h00;
        sel = 3'b101;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rc(9'h100, 8'h08);
        rc(9'h080, 8'hff);
        rc(9'h1ff, 8'h00);
        t_page;
        t_addr;
        t_prot;
        close_out;
    end
endmodule
